// ==== core/cawu_pkg.sv ====
// Shared constants and state types of the configuration and auto wakeup register bank.
package cawu_pkg;

	localparam int unsigned CLK_HZ = 20000000;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
	localparam logic [7:0] IDX_KBD_WAKE_STATUS_CTRL = 8'h10;
	localparam logic [7:0] IDX_KBD_WAKE_ENABLE = 8'h11;
	localparam logic [7:0] IDX_OPTION_REG_B = 8'h1E;
	localparam logic [7:0] IDX_OPTION_REG_A = 8'h1F;

	// Field positions of option_reg_a.
	localparam int unsigned A_PERIOD_SELECT = 7;
	localparam int unsigned A_LOWVOLT_IN_STOP = 6;
	localparam int unsigned A_LOWVOLT_RESET_DISABLE = 5;
	localparam int unsigned A_LOWVOLT_POWER_DISABLE = 4;
	localparam int unsigned A_LOWVOLT_VOLTAGE_MODE = 3;
	localparam int unsigned A_SHORT_STOP_RECOVERY = 2;
	localparam int unsigned A_STOP_ENABLE = 1;
	localparam int unsigned A_WATCHDOG_DISABLE = 0;

	// Field positions of option_reg_b.
	localparam int unsigned B_IRQ_PULLUP_OFF = 7;
	localparam int unsigned B_IRQ_PIN_FUNCTION = 6;
	localparam int unsigned B_OSC_SELECT_HI = 4;
	localparam int unsigned B_OSC_SELECT_LO = 3;
	localparam int unsigned B_RESET_PIN_FUNCTION = 0;

	// Field positions of the shared keyboard and wakeup registers.
	localparam int unsigned P_WAKE_PENDING_LATCH = 6;
	localparam int unsigned S_SHARED_IRQ_FLAG = 3;
	localparam int unsigned S_SHARED_IRQ_ACK = 2;
	localparam int unsigned S_SHARED_IRQ_MASK = 1;
	localparam int unsigned E_WAKE_IRQ_ENABLE = 6;
	localparam int unsigned KBD_PIN_ENABLES = 6;

	// Oscillator source encodings.
	localparam logic [1:0] OSC_INTERNAL = 2'h0;
	localparam logic [1:0] OSC_EXTERNAL = 2'h1;
	localparam logic [1:0] OSC_EXT_RC = 2'h2;
	localparam logic [1:0] OSC_EXT_XTAL = 2'h3;

	// Periods, counted in bus_clock_x4 or wake_rc_osc cycles.
	localparam logic [17:0] WDOG_SHORT_CYCLES = 18'h01FF0;
	localparam logic [17:0] WDOG_LONG_CYCLES = 18'h3FFF0;
	localparam logic [14:0] WAKE_SHORT_CYCLES = 15'h0200;
	localparam logic [14:0] WAKE_LONG_CYCLES = 15'h4000;
	localparam logic [12:0] RECOVERY_SHORT_CYCLES = 13'h0020;
	localparam logic [12:0] RECOVERY_LONG_CYCLES = 13'h1000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic osc_sync1;
		logic osc_sync2;
		logic osc_prev;
		logic stop_prev;
		logic [14:0] count;
		logic overflow;
	} cawu_timer_t;

	typedef struct packed {
		logic reset_pin_function;
		logic lowvolt_voltage_mode;
	} cawu_por_t;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] hrdata;
		logic [7:0] option_a;
		logic [7:0] option_b;
		logic option_a_done;
		logic option_b_done;
		logic wake_pending_latch;
		logic shared_irq_mask;
		logic wake_irq_enable;
		logic [5:0] kbd_pin_enable;
		logic kbd_ack;
		logic [12:0] recovery_cycles;
	} cawu_state_t;

endpackage

// ==== core/cawu_wake_timer.sv ====
// Periodic stop-mode wakeup counter clocked by the sampled wake oscillator pin.
`timescale 1ns/100ps
module cawu_wake_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wake_rc_osc,
	input wire logic stop_mode,
	input wire logic wake_irq_enable,
	input wire logic period_select,
	output logic wake_request
);

	cawu_pkg::cawu_timer_t s_r;
	cawu_pkg::cawu_timer_t s_nxt;
	logic [14:0] limit;
	logic osc_edge;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.osc_sync1 = wake_rc_osc;
		s_nxt.osc_sync2 = s_r.osc_sync1;
		s_nxt.osc_prev = s_r.osc_sync2;
		s_nxt.stop_prev = stop_mode;
		s_nxt.overflow = 1'b0;
		limit = period_select ? cawu_pkg::WAKE_SHORT_CYCLES : cawu_pkg::WAKE_LONG_CYCLES;
		osc_edge = s_r.osc_sync2 & ~s_r.osc_prev;
		// The oscillator is a foreign clock, so only its synchronised rising edge advances the count.
		if (stop_mode && !s_r.stop_prev)
		begin
			s_nxt.count = 15'h0000;
		end
		else if (stop_mode && wake_irq_enable && osc_edge)
		begin
			if (s_r.count == limit - 15'h0001)
			begin
				s_nxt.count = 15'h0000;
				s_nxt.overflow = 1'b1;
			end
			else
			begin
				s_nxt.count = s_r.count + 15'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign wake_request = s_r.overflow;

endmodule

// ==== core/cawu_core.sv ====
// Write-once option registers and shared keyboard/auto wakeup request logic on an AHB-Lite slave.
`timescale 1ns/100ps
// Contract
// - Wake timer runs in stop when enabled.
// - Wake counter restarts at zero per stop.
// - Unmasked request brings the part out of stop.
// - Port bit reads pending wake latch.
// - Flag shows keyboard or wake pending.
// - Ack write clears requests, reads zero.
// - Mask blocks interrupts; reset clears mask.
// - Wake enable gates latching; reset clears it.
// - Option registers write once, always readable.
// - Two-bit oscillator source selection.
// - IRQ pin function enable bit.
// - Reset pin bit cleared only by power-on.
// - Period select picks watchdog timeout.
// - Period select picks stop wakeup period.
// - Low-voltage stop bit keeps it running.
// - Disable bit suppresses low-voltage resets.
// - Power disable bit turns inhibit off.
// - Voltage mode bit, power-on reset only.
// - Short recovery picks 32 or 4096.
// - Low-voltage reset exit always uses long recovery.
// - Stop disabled makes STOP illegal.
// - Wake pending sits at port bit six.
// - Counter overflow latches a wakeup request.
// - Reset clears latch; enable ignores readback.
module cawu_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic por_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wake_rc_osc,
	input wire logic stop_mode,
	input wire logic kbd_irq_pending,
	input wire logic lvi_reset_exit,
	output logic kbd_ack,
	output logic [5:0] kbd_pin_enable,
	output logic cpu_irq,
	output logic stop_wakeup,
	output logic [1:0] osc_select,
	output logic irq_pullup_off,
	output logic irq_pin_function,
	output logic reset_pin_function,
	output logic [17:0] watchdog_timeout_cycles,
	output logic watchdog_enable,
	output logic stop_instr_enable,
	output logic [12:0] stop_recovery_cycles,
	output logic lowvolt_powered,
	output logic lowvolt_reset_enable,
	output logic lowvolt_voltage_mode
);

	cawu_pkg::cawu_state_t s_r;
	cawu_pkg::cawu_state_t s_nxt;
	cawu_pkg::cawu_por_t p_r;
	cawu_pkg::cawu_por_t p_nxt;
	logic wake_request;
	logic addr_take;
	logic wr_data;
	logic [7:0] wbyte;
	logic shared_irq_flag;

	cawu_wake_timer u_wake_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.wake_rc_osc(wake_rc_osc),
		.stop_mode(stop_mode),
		.wake_irq_enable(s_r.wake_irq_enable),
		.period_select(s_r.option_a[cawu_pkg::A_PERIOD_SELECT]),
		.wake_request(wake_request)
	);

	// Builds the readback of one register from a state copy and the power-on bits.
	function automatic logic [7:0] read_reg(
		input cawu_pkg::cawu_state_t st,
		input cawu_pkg::cawu_por_t pt,
		input logic kbd_pend,
		input logic [7:0] idx
	);
		logic [7:0] v;
		v = cawu_pkg::ZERO_BYTE;
		case (idx)
			cawu_pkg::IDX_PORT_A_DATA:
			begin
				v[cawu_pkg::P_WAKE_PENDING_LATCH] = st.wake_pending_latch;
			end
			cawu_pkg::IDX_KBD_WAKE_STATUS_CTRL:
			begin
				v[cawu_pkg::S_SHARED_IRQ_FLAG] = kbd_pend | st.wake_pending_latch;
				v[cawu_pkg::S_SHARED_IRQ_ACK] = 1'b0;
				v[cawu_pkg::S_SHARED_IRQ_MASK] = st.shared_irq_mask;
			end
			cawu_pkg::IDX_KBD_WAKE_ENABLE:
			begin
				v[cawu_pkg::E_WAKE_IRQ_ENABLE] = st.wake_irq_enable;
				v[cawu_pkg::KBD_PIN_ENABLES-1:0] = st.kbd_pin_enable;
			end
			cawu_pkg::IDX_OPTION_REG_A:
			begin
				v = st.option_a;
				v[cawu_pkg::A_LOWVOLT_VOLTAGE_MODE] = pt.lowvolt_voltage_mode;
			end
			cawu_pkg::IDX_OPTION_REG_B:
			begin
				v = st.option_b;
				v[cawu_pkg::B_RESET_PIN_FUNCTION] = pt.reset_pin_function;
			end
			default:
			begin
				v = cawu_pkg::ZERO_BYTE;
			end
		endcase
		return v;
	endfunction

	// Word-aligned byte address to register index.
	function automatic logic [7:0] addr_to_idx(input logic [31:0] a);
		return a[9:2];
	endfunction

	always_comb
	begin
		s_nxt = s_r;
		p_nxt = p_r;
		addr_take = hsel && hready && htrans[1];
		wr_data = s_r.wr_pend;
		wbyte = hwdata[7:0];
		s_nxt.kbd_ack = 1'b0;

		// Write data phase of the previous address phase.
		if (wr_data)
		begin
			case (s_r.wr_idx)
				cawu_pkg::IDX_KBD_WAKE_STATUS_CTRL:
				begin
					s_nxt.shared_irq_mask = wbyte[cawu_pkg::S_SHARED_IRQ_MASK];
					if (wbyte[cawu_pkg::S_SHARED_IRQ_ACK])
					begin
						s_nxt.wake_pending_latch = 1'b0;
						s_nxt.kbd_ack = 1'b1;
					end
				end
				cawu_pkg::IDX_KBD_WAKE_ENABLE:
				begin
					s_nxt.wake_irq_enable = wbyte[cawu_pkg::E_WAKE_IRQ_ENABLE];
					s_nxt.kbd_pin_enable = wbyte[cawu_pkg::KBD_PIN_ENABLES-1:0];
				end
				cawu_pkg::IDX_OPTION_REG_A:
				begin
					// A second write after reset is dropped silently; the bus still answers OKAY.
					if (!s_r.option_a_done)
					begin
						s_nxt.option_a = wbyte;
						s_nxt.option_a[cawu_pkg::A_LOWVOLT_VOLTAGE_MODE] = 1'b0;
						s_nxt.option_a_done = 1'b1;
						p_nxt.lowvolt_voltage_mode = wbyte[cawu_pkg::A_LOWVOLT_VOLTAGE_MODE];
					end
				end
				cawu_pkg::IDX_OPTION_REG_B:
				begin
					if (!s_r.option_b_done)
					begin
						s_nxt.option_b = wbyte;
						s_nxt.option_b[cawu_pkg::B_RESET_PIN_FUNCTION] = 1'b0;
						s_nxt.option_b_done = 1'b1;
						p_nxt.reset_pin_function = wbyte[cawu_pkg::B_RESET_PIN_FUNCTION];
					end
				end
				default:
				begin
					s_nxt.wr_pend = 1'b0;
				end
			endcase
		end

		// A timer overflow in the same cycle as an acknowledge wins, so no wakeup is lost.
		if (wake_request && s_r.wake_irq_enable)
		begin
			s_nxt.wake_pending_latch = 1'b1;
		end

		// Recovery length is reloaded every cycle from the option bit and the low-voltage reset exit input.
		if (s_r.option_a[cawu_pkg::A_SHORT_STOP_RECOVERY] && !lvi_reset_exit)
		begin
			s_nxt.recovery_cycles = cawu_pkg::RECOVERY_SHORT_CYCLES;
		end
		else
		begin
			s_nxt.recovery_cycles = cawu_pkg::RECOVERY_LONG_CYCLES;
		end

		// Address phase: note writes and prepare read data from the updated copy.
		s_nxt.wr_pend = addr_take && hwrite;
		s_nxt.wr_idx = addr_to_idx(haddr);
		if (addr_take && !hwrite)
		begin
			s_nxt.hrdata = {24'h000000, read_reg(s_nxt, p_nxt, kbd_irq_pending, addr_to_idx(haddr))};
		end
		else
		begin
			s_nxt.hrdata = cawu_pkg::ZERO_WORD;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '0;
			s_r.recovery_cycles <= cawu_pkg::RECOVERY_LONG_CYCLES;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// These two bits survive every reset except power-on.
	always_ff @(posedge hclk or negedge por_n)
	begin
		if (!por_n)
		begin
			p_r <= '0;
		end
		else
		begin
			p_r <= p_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_r.hrdata;
	assign kbd_ack = s_r.kbd_ack;
	assign kbd_pin_enable = s_r.kbd_pin_enable;

	assign shared_irq_flag = kbd_irq_pending | s_r.wake_pending_latch;
	assign cpu_irq = shared_irq_flag & ~s_r.shared_irq_mask;
	assign stop_wakeup = cpu_irq & stop_mode;

	assign osc_select = {s_r.option_b[cawu_pkg::B_OSC_SELECT_HI], s_r.option_b[cawu_pkg::B_OSC_SELECT_LO]};
	assign irq_pullup_off = s_r.option_b[cawu_pkg::B_IRQ_PULLUP_OFF];
	assign irq_pin_function = s_r.option_b[cawu_pkg::B_IRQ_PIN_FUNCTION];
	assign reset_pin_function = p_r.reset_pin_function;

	assign watchdog_timeout_cycles = s_r.option_a[cawu_pkg::A_PERIOD_SELECT] ?
		cawu_pkg::WDOG_SHORT_CYCLES : cawu_pkg::WDOG_LONG_CYCLES;
	assign watchdog_enable = ~s_r.option_a[cawu_pkg::A_WATCHDOG_DISABLE];
	assign stop_instr_enable = s_r.option_a[cawu_pkg::A_STOP_ENABLE];
	assign stop_recovery_cycles = s_r.recovery_cycles;

	// In stop the inhibit stays up only when the stop bit asks for it and power is not disabled.
	assign lowvolt_powered = ~s_r.option_a[cawu_pkg::A_LOWVOLT_POWER_DISABLE] &
		(~stop_mode | s_r.option_a[cawu_pkg::A_LOWVOLT_IN_STOP]);
	assign lowvolt_reset_enable = lowvolt_powered & ~s_r.option_a[cawu_pkg::A_LOWVOLT_RESET_DISABLE];
	assign lowvolt_voltage_mode = p_r.lowvolt_voltage_mode;

endmodule

// ==== dv/cawu_core_sva.sv ====
// Port-level assertions for the configuration and auto wakeup register bank.
`timescale 1ns/100ps
module cawu_core_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic stop_mode,
	input wire logic lvi_reset_exit,
	input wire logic kbd_ack,
	input wire logic cpu_irq,
	input wire logic stop_wakeup,
	input wire logic [17:0] watchdog_timeout_cycles,
	input wire logic watchdog_enable,
	input wire logic [12:0] stop_recovery_cycles,
	input wire logic lowvolt_powered,
	input wire logic lowvolt_reset_enable
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay; hreadyout && !hresp && hrdata[31:8] == 24'h000000; endproperty
	property p_wake; stop_wakeup == (cpu_irq && stop_mode); endproperty
	property p_wdog; watchdog_timeout_cycles inside {18'h01FF0, 18'h3FFF0}; endproperty
	property p_recov; stop_recovery_cycles inside {13'h0020, 13'h1000}; endproperty
	property p_lvrec; lvi_reset_exit |=> stop_recovery_cycles == 13'h1000; endproperty
	property p_ack; kbd_ack |=> !kbd_ack; endproperty
	property p_lvi; lowvolt_reset_enable |-> lowvolt_powered; endproperty
	property p_optw; $changed(watchdog_enable) |-> $past(hsel && hwrite && htrans == 2'h2, 2); endproperty
	a_okay: assert property (p_okay) else $error("bus answer not OKAY");
	a_wake: assert property (p_wake) else $error("stop wakeup mismatch");
	a_wdog: assert property (p_wdog) else $error("bad watchdog period");
	a_recov: assert property (p_recov) else $error("bad recovery delay");
	a_lvrec: assert property (p_lvrec) else $error("short recovery after lvi exit");
	a_ack: assert property (p_ack) else $error("ack pulse too long");
	a_lvi: assert property (p_lvi) else $error("lvi reset while unpowered");
	a_optw: assert property (p_optw) else $error("option changed without write");
	c_ack: cover property (kbd_ack);
	c_wake: cover property ($rose(stop_wakeup));
	c_lvrec: cover property ($rose(lvi_reset_exit));
endmodule
bind cawu_core cawu_core_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode), .lvi_reset_exit(lvi_reset_exit),
	.kbd_ack(kbd_ack), .cpu_irq(cpu_irq), .stop_wakeup(stop_wakeup), .watchdog_timeout_cycles(watchdog_timeout_cycles),
	.watchdog_enable(watchdog_enable), .stop_recovery_cycles(stop_recovery_cycles), .lowvolt_powered(lowvolt_powered),
	.lowvolt_reset_enable(lowvolt_reset_enable));

// ==== dv/testbench.sv ====
// Self-checking bench for the configuration and auto wakeup register bank.
`timescale 1ns/100ps
module testbench;
	localparam logic [7:0] RA = cawu_pkg::IDX_OPTION_REG_A;
	localparam logic [7:0] RB = cawu_pkg::IDX_OPTION_REG_B;
	localparam logic [7:0] RP = cawu_pkg::IDX_PORT_A_DATA;
	localparam logic [7:0] RS = cawu_pkg::IDX_KBD_WAKE_STATUS_CTRL;
	localparam logic [7:0] RE = cawu_pkg::IDX_KBD_WAKE_ENABLE;
	logic hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, osc_select;
	logic [2:0] hsize;
	logic wake_rc_osc, stop_mode, kbd_irq_pending, lvi_reset_exit, kbd_ack, cpu_irq, stop_wakeup;
	logic irq_pullup_off, irq_pin_function, reset_pin_function, watchdog_enable, stop_instr_enable;
	logic lowvolt_powered, lowvolt_reset_enable, lowvolt_voltage_mode;
	logic [5:0] kbd_pin_enable;
	logic [17:0] watchdog_timeout_cycles;
	logic [12:0] stop_recovery_cycles;
	int failures, total_checks;
	assign hready = hreadyout;
	cawu_core dut (
		.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .wake_rc_osc(wake_rc_osc), .stop_mode(stop_mode),
		.kbd_irq_pending(kbd_irq_pending), .lvi_reset_exit(lvi_reset_exit), .kbd_ack(kbd_ack),
		.kbd_pin_enable(kbd_pin_enable), .cpu_irq(cpu_irq), .stop_wakeup(stop_wakeup),
		.osc_select(osc_select), .irq_pullup_off(irq_pullup_off), .irq_pin_function(irq_pin_function),
		.reset_pin_function(reset_pin_function), .watchdog_timeout_cycles(watchdog_timeout_cycles),
		.watchdog_enable(watchdog_enable), .stop_instr_enable(stop_instr_enable),
		.stop_recovery_cycles(stop_recovery_cycles), .lowvolt_powered(lowvolt_powered),
		.lowvolt_reset_enable(lowvolt_reset_enable), .lowvolt_voltage_mode(lowvolt_voltage_mode)
	);
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Ready and read data are taken at the rising edge, before the design's registers move.
	task automatic wt();
		do
		begin
			@(posedge hclk);
		end
		while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'h0};
		hwrite <= wr;
		htrans <= cawu_pkg::HTRANS_NONSEQ;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		wt();
		// One idle cycle lets a written option reach the ports before they are compared.
		@(posedge hclk);
	endtask
	task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
		bus(idx, 1'b0, 8'h00);
		chk(n, rd, {24'h000000, e});
	endtask
	task automatic osc(input int n);
		repeat (n)
		begin
			wake_rc_osc <= 1'b1;
			repeat (2) @(posedge hclk);
			wake_rc_osc <= 1'b0;
			repeat (2) @(posedge hclk);
		end
		repeat (8) @(posedge hclk);
	endtask
	task automatic rst(input logic p);
		hresetn <= 1'b0;
		por_n <= !p;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge hclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge hclk);
		failures++;
		end_of_test();
	end
	initial
	begin
		{hresetn, por_n, hsel, hwrite, wake_rc_osc, stop_mode, kbd_irq_pending, lvi_reset_exit} = 8'h00;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'h0;
		hsize = 3'h2;
		failures = 0;
		total_checks = 0;
		rst(1'b1);
		chk("wdog_en", watchdog_enable, 32'h00000001);
		chk("wdog_t", watchdog_timeout_cycles, 32'h0003FFF0);
		for (int i = 0; i < 4; i++)
		begin
			rst(1'b1);
			bus(RB, 1'b1, {i[0], 1'b1, 1'b0, i[1:0], 3'h1});
			chk("osc", osc_select, i);
			chk("irq_pin", irq_pin_function, 32'h00000001);
			chk("pullup", irq_pullup_off, i[0]);
		end
		bus(RB, 1'b1, 8'h00);
		rchk("opt_b", RB, 8'hD9);
		bus(RA, 1'b1, 8'h8E);
		bus(RA, 1'b1, 8'h01);
		rchk("opt_a", RA, 8'h8E);
		chk("wdog_t", watchdog_timeout_cycles, 32'h00001FF0);
		chk("wdog_en", watchdog_enable, 32'h00000001);
		chk("stop_en", stop_instr_enable, 32'h00000001);
		chk("recov", stop_recovery_cycles, 32'h00000020);
		chk("lv_rst", lowvolt_reset_enable, 32'h00000001);
		lvi_reset_exit <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("recov_lvi", stop_recovery_cycles, 32'h00001000);
		lvi_reset_exit <= 1'b0;
		rst(1'b0);
		chk("rst_pin", reset_pin_function, 32'h00000001);
		chk("lv_mode", lowvolt_voltage_mode, 32'h00000001);
		chk("irq_pin", irq_pin_function, 32'h00000000);
		bus(RA, 1'b1, 8'hC1);
		chk("wdog_en", watchdog_enable, 32'h00000000);
		bus(8'h05, 1'b1, 8'hFF);
		rchk("unmapped", 8'h05, 8'h00);
		bus(RE, 1'b1, 8'h55);
		rchk("kb_en", RE, 8'h55);
		chk("kb_pins", kbd_pin_enable, 32'h00000015);
		stop_mode <= 1'b1;
		osc(300);
		stop_mode <= 1'b0;
		@(posedge hclk);
		stop_mode <= 1'b1;
		osc(300);
		rchk("port", RP, 8'h00);
		chk("lv_pwr", lowvolt_powered, 32'h00000001);
		osc(211);
		rchk("port", RP, 8'h00);
		osc(1);
		rchk("port", RP, 8'h40);
		chk("irq", cpu_irq, 32'h00000001);
		chk("stop_wake", stop_wakeup, 32'h00000001);
		rchk("status", RS, 8'h08);
		bus(RS, 1'b1, 8'h02);
		chk("irq", cpu_irq, 32'h00000000);
		rchk("status", RS, 8'h0A);
		bus(RE, 1'b1, 8'h00);
		rchk("port", RP, 8'h40);
		bus(RS, 1'b1, 8'h04);
		rchk("port", RP, 8'h00);
		rchk("status", RS, 8'h00);
		osc(520);
		rchk("port", RP, 8'h00);
		stop_mode <= 1'b0;
		kbd_irq_pending <= 1'b1;
		@(posedge hclk);
		chk("irq", cpu_irq, 32'h00000001);
		rchk("status", RS, 8'h08);
		kbd_irq_pending <= 1'b0;
		rst(1'b1);
		chk("rst_pin", reset_pin_function, 32'h00000000);
		chk("lv_mode", lowvolt_voltage_mode, 32'h00000000);
		end_of_test();
	end
endmodule
